// ===== dar_params.svh
`ifndef DAR_PARAMS_SVH
`define DAR_PARAMS_SVH

// Result and frame layout
`define DAR_RES_W          12
`define DAR_FRAME_BITS     32
`define DAR_FIFO_DEPTH     16

// Falling-edge positions inside a frame
`define DAR_CNT_PD_MIN     6'd2
`define DAR_CNT_AWAKE_MIN  6'd10
`define DAR_CNT_TRACK      6'd13
`define DAR_CNT_RELEASE    6'd31
`define DAR_CNT_MAX        6'h3f

// Timing, in the unit of each figure
`define DAR_CLK_PERIOD_NS  40
`define DAR_PART_WAKE_NS   1000
`define DAR_PART_DWELL_NS  67000
`define DAR_FULL_WAKE_NS   1500000

// Least times, rounded up to whole cycles
`define DAR_PART_WAKE_CYC  ((`DAR_PART_WAKE_NS + `DAR_CLK_PERIOD_NS - 1) / `DAR_CLK_PERIOD_NS)
`define DAR_PART_DWELL_CYC ((`DAR_PART_DWELL_NS + `DAR_CLK_PERIOD_NS - 1) / `DAR_CLK_PERIOD_NS)
`define DAR_FULL_WAKE_CYC  ((`DAR_FULL_WAKE_NS + `DAR_CLK_PERIOD_NS - 1) / `DAR_CLK_PERIOD_NS)

`endif

// ===== dar_pkg.sv
package dar_pkg;
    // Power state of the converter core
    typedef enum logic [1:0] {
        DAR_PWR_NORMAL,
        DAR_PWR_PARTIAL,
        DAR_PWR_FULL
    } dar_pwr_t;

    // One sample pair: result A in the upper half
    typedef logic [23:0] dar_pair_t;
endpackage

// ===== dar_stream_if.sv
`timescale 1ns/1ps
interface dar_stream_if #(
    parameter int WIDTH = 24
);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    // The FIFO sees both sides; the user fills one and drains the other
    modport fifo_side (
        input  wr_valid,
        output wr_ready,
        input  wr_data,
        output rd_valid,
        input  rd_ready,
        output rd_data
    );
    modport user_side (
        output wr_valid,
        input  wr_ready,
        output wr_data,
        input  rd_valid,
        output rd_ready,
        input  rd_data
    );
endinterface

// ===== dar_fifo.sv
`timescale 1ns/1ps
module dar_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic     clk,
    input  wire logic     srst,
    dar_stream_if.fifo_side st
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;

    wire [AW:0] fill     = wr_ptr_ff - rd_ptr_ff;
    // Compare at full pointer width; a narrower cast of DEPTH would wrap to zero
    wire        is_full  = (fill == (AW+1)'(DEPTH));
    wire        is_empty = (fill == '0);
    wire        do_wr    = st.wr_valid & ~is_full;
    wire        do_rd    = st.rd_ready & ~is_empty;

    // Handshake flags straight from the pointers
    assign st.wr_ready = ~is_full;
    assign st.rd_valid = ~is_empty;
    assign st.rd_data  = mem_ff[rd_ptr_ff[AW-1:0]];

    // Storage has no reset; only the pointers are reset
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= st.wr_data;
        end
    end

    // Extra pointer bit tells full from empty
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + (AW+1)'(do_wr);
            rd_ptr_ff <= rd_ptr_ff + (AW+1)'(do_rd);
        end
    end
endmodule

// ===== dar_readout.sv
// How it works
// - Partial wake short only after long dwell
// - Frame fall holds, samples, starts, drives outputs
// - Track again at rise after thirteenth fall
// - Sixteen clocks give two trailing zero bits
// - Frame rise ends conversion, releases both outputs
// - Longer frame shifts other result on line
// - Release line at 32nd fall or rise
// - Two leading zeros, then result MSB first
// - Clock fall coincident with frame fall ignored
// - Rising clock before first fall ignored
// - Serial clock paces all conversion and shifting
// - Early rise aborts, normal goes partial
// - Rise between 10 and 14 stays powered
// - Early rise from partial goes full down
// - Rise before second fall keeps power state
`timescale 1ns/1ps
`include "dar_params.svh"
module dar_readout
    import dar_pkg::*;
#(
    parameter int RES_W         = `DAR_RES_W,
    parameter int FIFO_DEPTH    = `DAR_FIFO_DEPTH,
    parameter int FULL_WAKE_CYC = `DAR_FULL_WAKE_CYC
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             frame_n,
    input  wire logic             sclk,
    input  wire logic             sample_valid,
    output wire logic             sample_ready,
    input  wire logic [RES_W-1:0] sample_a,
    input  wire logic [RES_W-1:0] sample_b,
    output wire logic             serial_result_out_a,
    output wire logic             serial_result_out_a_oe_n,
    output wire logic             serial_result_out_b,
    output wire logic             serial_result_out_b_oe_n,
    output wire logic             hold_active,
    output wire logic             analog_on,
    output wire logic             core_ready,
    output wire logic [1:0]       power_state
);
    localparam int FB     = `DAR_FRAME_BITS;
    localparam int PW_CYC = `DAR_PART_WAKE_CYC;
    localparam int PD_CYC = `DAR_PART_DWELL_CYC;
    localparam int WK_W   = $clog2(FULL_WAKE_CYC + 1);
    localparam int DW_W   = $clog2(PD_CYC + 1);

    // Carrier between this block and its sample buffer
    dar_stream_if #(.WIDTH(2 * RES_W)) st ();

    dar_fifo #(
        .WIDTH (2 * RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk  (clk),
        .srst (srst),
        .st   (st)
    );

    // Pin synchronisers and edge history
    logic [1:0] pin_meta_ff;
    logic [1:0] pin_sync_ff;
    logic [1:0] pin_prev_ff;

    // Frame state
    logic [5:0]    fall_cnt_ff;
    logic [FB-1:0] shift_a_ff;
    logic [FB-1:0] shift_b_ff;
    logic          drive_ff;
    logic          hold_ff;

    // Power state
    dar_pwr_t      pwr_ff;
    logic          waking_ff;
    logic [WK_W-1:0] wake_cnt_ff;
    logic [DW_W-1:0] dwell_cnt_ff;
    logic          ready_ff;

    // Two flops per pin before any logic looks at it
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta_ff <= 2'h3;
            pin_sync_ff <= 2'h3;
            pin_prev_ff <= 2'h3;
        end else begin
            pin_meta_ff <= {sclk, frame_n};
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // Edge decode on the synchronised pins
    wire frame_low  = ~pin_sync_ff[0];
    wire frame_fall = pin_prev_ff[0] & ~pin_sync_ff[0];
    wire frame_rise = ~pin_prev_ff[0] & pin_sync_ff[0];
    wire sclk_fall  = pin_prev_ff[1] & ~pin_sync_ff[1];
    wire sclk_rise  = ~pin_prev_ff[1] & pin_sync_ff[1];
    // Falls only count inside the frame, never in its first cycle
    wire count_fall = frame_low & ~frame_fall & sclk_fall;

    // Sample pair taken from the buffer at frame fall
    wire             pair_ok = st.rd_valid;
    wire [RES_W-1:0] res_a   = pair_ok ? st.rd_data[2*RES_W-1:RES_W] : '0;
    wire [RES_W-1:0] res_b   = pair_ok ? st.rd_data[RES_W-1:0] : '0;

    // Leading zeros, result, trailing zeros, then the other result
    wire [FB-1:0] word_a = {2'h0, res_a, 2'h0, 2'h0, res_b, 2'h0};
    wire [FB-1:0] word_b = {2'h0, res_b, 2'h0, 2'h0, res_a, 2'h0};

    // Buffer hooks: filled by the sampler, drained one pair per frame
    assign st.wr_valid = sample_valid;
    assign st.wr_data  = {sample_a, sample_b};
    assign st.rd_ready = frame_fall;
    assign sample_ready = st.wr_ready;

    // Power decision made from the count at frame rise
    wire rise_keep   = fall_cnt_ff < `DAR_CNT_PD_MIN;
    wire rise_awake  = fall_cnt_ff >= `DAR_CNT_AWAKE_MIN;
    wire release_now = count_fall & (fall_cnt_ff == `DAR_CNT_RELEASE);

    // Wake time chosen at frame fall from the current state
    wire dwell_done = (dwell_cnt_ff == DW_W'(PD_CYC));
    wire [WK_W-1:0] wake_load =
        (pwr_ff == DAR_PWR_NORMAL)                ? '0 :
        (pwr_ff == DAR_PWR_PARTIAL && dwell_done) ? WK_W'(PW_CYC) :
                                                    WK_W'(FULL_WAKE_CYC);

    dar_pwr_t nxt_pwr;

    // Next power state at the end of a frame
    always_comb begin
        nxt_pwr = pwr_ff;
        if (frame_rise && !rise_keep) begin
            if (rise_awake) begin
                nxt_pwr = DAR_PWR_NORMAL;
            end else begin
                case (pwr_ff)
                    DAR_PWR_NORMAL:  nxt_pwr = DAR_PWR_PARTIAL;
                    DAR_PWR_PARTIAL: nxt_pwr = DAR_PWR_FULL;
                    DAR_PWR_FULL:    nxt_pwr = DAR_PWR_FULL;
                    default:         nxt_pwr = DAR_PWR_FULL;
                endcase
            end
        end
    end

    // Frame-relative falling edge count, saturating
    always_ff @(posedge clk) begin
        if (srst) begin
            fall_cnt_ff <= 6'h00;
        end else if (frame_fall) begin
            fall_cnt_ff <= 6'h00;
        end else if (count_fall && fall_cnt_ff != `DAR_CNT_MAX) begin
            fall_cnt_ff <= fall_cnt_ff + 6'h01;
        end
    end

    // Output shifters: one bit per counted fall, MSB first
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_a_ff <= '0;
            shift_b_ff <= '0;
        end else if (frame_fall) begin
            shift_a_ff <= word_a;
            shift_b_ff <= word_b;
        end else if (count_fall) begin
            shift_a_ff <= {shift_a_ff[FB-2:0], 1'b0};
            shift_b_ff <= {shift_b_ff[FB-2:0], 1'b0};
        end
    end

    // Output drive: on at fall, off at rise or after 32 falls
    always_ff @(posedge clk) begin
        if (srst) begin
            drive_ff <= 1'b0;
        end else if (frame_fall) begin
            drive_ff <= 1'b1;
        end else if (frame_rise || release_now) begin
            drive_ff <= 1'b0;
        end
    end

    // Track-and-hold: hold from frame fall, track after 13 falls
    always_ff @(posedge clk) begin
        if (srst) begin
            hold_ff <= 1'b0;
        end else if (frame_fall) begin
            hold_ff <= 1'b1;
        end else if (frame_rise) begin
            hold_ff <= 1'b0;
        end else if (sclk_rise && fall_cnt_ff >= `DAR_CNT_TRACK) begin
            hold_ff <= 1'b0;
        end
    end

    // Power state register
    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_ff <= DAR_PWR_NORMAL;
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end

    // Analog core stays up while a wake frame is held low
    always_ff @(posedge clk) begin
        if (srst) begin
            waking_ff <= 1'b0;
        end else if (frame_fall) begin
            waking_ff <= (pwr_ff != DAR_PWR_NORMAL);
        end else if (frame_rise) begin
            waking_ff <= 1'b0;
        end
    end

    // Wake countdown; an aborted wake frame drops it again
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_cnt_ff <= '0;
        end else if (frame_fall) begin
            wake_cnt_ff <= wake_load;
        end else if (frame_rise && !rise_awake && pwr_ff != DAR_PWR_NORMAL) begin
            wake_cnt_ff <= '0;
        end else if (wake_cnt_ff != '0) begin
            wake_cnt_ff <= wake_cnt_ff - WK_W'(1);
        end
    end

    // Time spent in partial power-down with the frame idle
    always_ff @(posedge clk) begin
        if (srst) begin
            dwell_cnt_ff <= '0;
        end else if (pwr_ff != DAR_PWR_PARTIAL || frame_low) begin
            dwell_cnt_ff <= '0;
        end else if (!dwell_done) begin
            dwell_cnt_ff <= dwell_cnt_ff + DW_W'(1);
        end
    end

    // Ready once powered and the wake time has run out
    always_ff @(posedge clk) begin
        if (srst) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= (nxt_pwr == DAR_PWR_NORMAL) && (wake_cnt_ff == '0);
        end
    end

    // Pins: enables are low while driving
    assign serial_result_out_a      = shift_a_ff[FB-1];
    assign serial_result_out_b      = shift_b_ff[FB-1];
    assign serial_result_out_a_oe_n = ~drive_ff;
    assign serial_result_out_b_oe_n = ~drive_ff;
    assign hold_active              = hold_ff;
    assign analog_on                = (pwr_ff == DAR_PWR_NORMAL) | waking_ff;
    assign core_ready               = ready_ff;
    assign power_state              = pwr_ff;
endmodule

// ===== dar_readout_asserts.sv
`timescale 1ns/1ps
module dar_chk #(
    parameter int FULL_WAKE_CYC = 50
) (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       frame_n,
    input wire logic       sclk,
    input wire logic       sample_ready,
    input wire logic       serial_result_out_a,
    input wire logic       serial_result_out_a_oe_n,
    input wire logic       serial_result_out_b,
    input wire logic       serial_result_out_b_oe_n,
    input wire logic       hold_active,
    input wire logic       analog_on,
    input wire logic       core_ready,
    input wire logic [1:0] power_state
);
    int low_cnt;
    int fall_age;
    // Wake time after the wake frame ends; the frame itself may run long
    always_ff @(posedge clk) begin
        low_cnt  <= (srst || core_ready || !analog_on || !frame_n) ? 0 : low_cnt + 1;
        fall_age <= $fell(sclk) ? 0 : ((fall_age < 99) ? fall_age + 1 : 99);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_rst;
        disable iff (1'b0) srst |=> serial_result_out_a_oe_n && serial_result_out_b_oe_n
            && !hold_active && power_state == 2'h0;
    endproperty
    property p_drive;
        $fell(frame_n) |-> ##[2:6] (!serial_result_out_a_oe_n && !serial_result_out_b_oe_n);
    endproperty
    property p_hold;
        $fell(frame_n) |-> ##[2:6] hold_active;
    endproperty
    property p_rel;
        $rose(frame_n) |-> ##[1:6] (serial_result_out_a_oe_n && serial_result_out_b_oe_n);
    endproperty
    property p_lead;
        $fell(serial_result_out_a_oe_n) |-> !serial_result_out_a && !serial_result_out_b;
    endproperty
    // Data may only move shortly after a clock pin fall
    property p_pace;
        $changed(serial_result_out_a) && !serial_result_out_a_oe_n
            && !$past(serial_result_out_a_oe_n) |-> fall_age <= 6;
    endproperty
    property p_state;
        $changed(power_state) |-> frame_n && $past(frame_n, 2);
    endproperty
    property p_wake;
        low_cnt <= FULL_WAKE_CYC + 8;
    endproperty
    property p_off;
        power_state != 2'h0 && frame_n && $past(frame_n, 6) |-> !analog_on;
    endproperty

    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_drive: assert property (p_drive) else $error("outputs not driven");
    a_hold: assert property (p_hold) else $error("no hold at frame start");
    a_rel: assert property (p_rel) else $error("outputs not released");
    a_lead: assert property (p_lead) else $error("first bit not zero");
    a_pace: assert property (p_pace) else $error("data moved without clock");
    a_state: assert property (p_state) else $error("state moved in frame");
    a_wake: assert property (p_wake) else $error("wake too long");
    a_off: assert property (p_off) else $error("core on while down");

    c_full: cover property (power_state == 2'h2);
    c_rel32: cover property ($rose(serial_result_out_a_oe_n) && !frame_n);
    c_buf: cover property (!sample_ready);
endmodule

// ===== dar_host.sv
`timescale 1ns/1ps
// Host serial port; clock idles high and stands still between frames
module dar_host (
    output logic      frame_n,
    output logic      sclk,
    input  wire logic out_a,
    input  wire logic oe_a_n,
    input  wire logic out_b,
    input  wire logic oe_b_n
);
    wire logic wa;
    wire logic wb;
    // No pull on the data lines, so a released line floats
    assign wa = oe_a_n ? 1'bz : out_a;
    assign wb = oe_b_n ? 1'bz : out_b;

    initial begin
        frame_n = 1'b1;
        sclk    = 1'b1;
    end

    // One frame of n clocks; each line sampled just before a fall
    task automatic xfer(input int n, output logic [31:0] ca, output logic [31:0] cb);
        ca = 32'h0;
        cb = 32'h0;
        #7;
        frame_n = 1'b0;
        #280;
        for (int k = 0; k < n; k++) begin
            ca   = {ca[30:0], wa};
            cb   = {cb[30:0], wb};
            sclk = 1'b0;
            #160;
            sclk = 1'b1;
            #160;
        end
        #80;
    endtask

    // End the frame and give the lines time to float
    task automatic stop();
        frame_n = 1'b1;
        #480;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    localparam int FWC = 50;
    logic        clk, srst, frame_n, sclk;
    logic        sample_valid, sample_ready;
    logic [11:0] sample_a, sample_b;
    logic        out_a, oe_a_n, out_b, oe_b_n;
    logic        hold_active, analog_on, core_ready;
    logic [1:0]  power_state;
    logic [31:0] ca, cb;
    int          err_total;
    int          total_checks;

    // 25 MHz system clock
    initial clk = 1'b0;
    always #20 clk = ~clk;

    dar_readout #(.FULL_WAKE_CYC(FWC)) uut (
        .clk(clk), .srst(srst), .frame_n(frame_n), .sclk(sclk),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_a(sample_a), .sample_b(sample_b),
        .serial_result_out_a(out_a), .serial_result_out_a_oe_n(oe_a_n),
        .serial_result_out_b(out_b), .serial_result_out_b_oe_n(oe_b_n),
        .hold_active(hold_active), .analog_on(analog_on),
        .core_ready(core_ready), .power_state(power_state));
    dar_host host (.frame_n(frame_n), .sclk(sclk), .out_a(out_a),
        .oe_a_n(oe_a_n), .out_b(out_b), .oe_b_n(oe_b_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Distinct pattern per pair; B is the inverse to catch swaps
    function automatic logic [11:0] av(input int i);
        return 12'h0f1 + 12'(i) * 12'h111;
    endfunction

    task automatic report_and_stop();
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Fill the buffer until it refuses the seventeenth pair
    task automatic s_fill();
        for (int i = 0; i < 17; i++) begin
            @(negedge clk);
            chk({31'h0, sample_ready}, {31'h0, (i < 16)});
            sample_valid = 1'b1;
            sample_a     = av(i);
            sample_b     = ~av(i);
        end
        @(negedge clk);
        sample_valid = 1'b0;
    endtask

    // Both results on each line; line floats after the last fall
    task automatic s_dual();
        host.xfer(32, ca, cb);
        chk(ca, {2'b0, av(0), 4'h0, ~av(0), 2'b0});
        chk(cb, {2'b0, ~av(0), 4'h0, av(0), 2'b0});
        chk({31'h0, host.wa}, {31'h0, 1'bz});
        host.stop();
        chk({31'h0, sample_ready}, 32'h1);
    endtask

    // 14 and 16 clocks in turn, draining to an empty buffer
    task automatic s_frames();
        int n;
        logic [11:0] ea;
        logic [11:0] eb;
        for (int j = 1; j < 17; j++) begin
            n  = (j % 2) ? 14 : 16;
            ea = (j < 16) ? av(j) : 12'h000;
            eb = (j < 16) ? ~av(j) : 12'h000;
            host.xfer(n, ca, cb);
            chk({31'h0, hold_active}, 32'h0);
            chk(ca, (n == 16) ? {18'h0, ea, 2'b0} : {20'h0, ea});
            chk(cb, (n == 16) ? {18'h0, eb, 2'b0} : {20'h0, eb});
            host.stop();
            chk({31'h0, host.wa}, {31'h0, 1'bz});
        end
    endtask

    // Late abort keeps power; it is also the first dummy cycle
    task automatic s_abort();
        host.xfer(12, ca, cb);
        host.stop();
        chk({30'h0, power_state}, 32'h0);
        chk({31'h0, host.wb}, {31'h0, 1'bz});
    endtask

    // Partial, full, a glitch frame, then a wake frame
    task automatic s_power();
        int w;
        host.xfer(5, ca, cb);
        chk({31'h0, hold_active}, 32'h1);
        host.stop();
        chk({30'h0, power_state}, 32'h1);
        host.xfer(5, ca, cb);
        host.stop();
        chk({30'h0, power_state}, 32'h2);
        host.xfer(1, ca, cb);
        host.stop();
        chk({30'h0, power_state}, 32'h2);
        host.xfer(12, ca, cb);
        host.stop();
        chk({30'h0, power_state}, 32'h0);
        w = 0;
        while (core_ready !== 1'b1 && w < 200) begin
            @(negedge clk);
            w++;
        end
        chk({31'h0, core_ready}, 32'h1);
        if (w == 200) report_and_stop();
    endtask

    initial begin
        err_total    = 0;
        total_checks = 0;
        srst         = 1'b1;
        sample_valid = 1'b0;
        sample_a     = 12'h000;
        sample_b     = 12'h000;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (5) @(negedge clk);
        s_fill();
        s_dual();
        s_frames();
        s_abort();
        s_power();
        report_and_stop();
    end
endmodule

bind dar_readout dar_chk #(.FULL_WAKE_CYC(FULL_WAKE_CYC)) u_chk (
    .clk(clk), .srst(srst), .frame_n(frame_n), .sclk(sclk),
    .sample_ready(sample_ready), .serial_result_out_a(serial_result_out_a),
    .serial_result_out_a_oe_n(serial_result_out_a_oe_n),
    .serial_result_out_b(serial_result_out_b),
    .serial_result_out_b_oe_n(serial_result_out_b_oe_n),
    .hold_active(hold_active), .analog_on(analog_on),
    .core_ready(core_ready), .power_state(power_state));
